// ---- design/clock_divider_map.vh ----
// Register map, field layout and constants of the clock divider and doze control
// Functional notes
// - With recover-on-interrupt set, an interrupt clears doze enable and restores ratio 1:1.
// - With recover-on-interrupt clear, interrupts leave doze enable and ratio untouched.
// - Three-bit doze ratio selects power-of-two ratio, 000 is 1:1, 111 is 1:128.
// - RC postscaler divides the 8 MHz RC clock by 1..64, and code 111 by 256.
// - System postscaler divides PLL branch: 01 by 2, 10 by 4, 11 by 8.
// - PLL enable keeps the PLL running; otherwise it runs only in oscillator modes 011 or 001.
`ifndef CLOCK_DIVIDER_MAP_VH
`define CLOCK_DIVIDER_MAP_VH
`define CDC_ADDR_W 4
`define CDC_ADDR_CTRL 4'h0
`define CDC_ADDR_STAT 4'h1
`define CDC_BIT_ROI 15
`define CDC_DOZE_HI 14
`define CDC_DOZE_LO 12
`define CDC_BIT_RATIO_APPLY_ENABLE 11
`define CDC_RC_HI 10
`define CDC_RC_LO 8
`define CDC_CP_HI 7
`define CDC_CP_LO 6
`define CDC_BIT_USB_PLL_ALWAYS_ON 5
`define CDC_WMASK 16'hFFE0
`define CDC_RESET_VAL 16'h3100
`define CDC_RC_MAX 3'h7
`define CDC_RC_DIV256_SHIFT 4'h8
`define CDC_PLL_MODE_A 3'h3
`define CDC_PLL_MODE_B 3'h1
`define CDC_CP_DIV2 2'h1
`define CDC_CNT_W 8
`endif

// ---- design/pow2_clock_gate.v ----
// Glitch-free power-of-two clock enable generator
`timescale 1ns/1ns
module pow2_clock_gate #(
	parameter CNT_W = 8
) (
	input wire sys_clk,
	input wire rst,
	input wire [3:0] shiftSel,
	output reg tickOut_r
);
	reg [CNT_W-1:0] cnt_r;
	reg [3:0] activeShift_r;
	wire [CNT_W-1:0] limit;
	wire wrap;
	assign limit = (({{(CNT_W-1){1'b0}}, 1'b1}) << activeShift_r) - {{(CNT_W-1){1'b0}}, 1'b1};
	assign wrap = (cnt_r == limit);
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= {CNT_W{1'b0}};
			activeShift_r <= 4'h0;
			tickOut_r <= 1'b0;
		end else begin
			tickOut_r <= wrap;
			if (wrap) begin
				// New ratio only adopted at a period boundary
				cnt_r <= {CNT_W{1'b0}};
				activeShift_r <= shiftSel;
			end else begin
				cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// ---- design/clock_divider_doze_control.v ----
// Clock divider and doze control register block
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "clock_divider_map.vh"
module clock_divider_doze_control #(
	parameter CNT_W = `CDC_CNT_W
) (
	input wire sys_clk,
	input wire rst,
	input wire [`CDC_ADDR_W-1:0] regAddr,
	input wire [15:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [15:0] regRdData_r,
	input wire intrEvent,
	input wire [2:0] oscModeSel,
	output reg rcClkEn_r,
	output reg sysClkEn_r,
	output reg periphClkEn_r,
	output reg pllRun_r,
	output reg [15:0] ctrlOut_r
);
	////////////////////////////////////////////////////////////
	reg [15:0] ctrl_r;
	reg [15:0] ctrl_nxt;
	reg intrSync1_r;
	reg intrSync2_r;
	reg [2:0] oscSync1_r;
	reg [2:0] oscSync2_r;
	wire rcTick;
	wire sysTick;
	wire periphTick;
	wire [2:0] dozeSel;
	wire [2:0] rcSel;
	wire [1:0] cpSel;
	wire [3:0] rcShift;
	wire [3:0] cpShift;
	wire [3:0] dozeShift;
	assign dozeSel = ctrl_r[`CDC_DOZE_HI:`CDC_DOZE_LO];
	assign rcSel = ctrl_r[`CDC_RC_HI:`CDC_RC_LO];
	assign cpSel = ctrl_r[`CDC_CP_HI:`CDC_CP_LO];
	assign rcShift = (rcSel == `CDC_RC_MAX) ? `CDC_RC_DIV256_SHIFT : {1'b0, rcSel};
	assign cpShift = {2'b00, cpSel};
	assign dozeShift = ctrl_r[`CDC_BIT_RATIO_APPLY_ENABLE] ? {1'b0, dozeSel} : 4'h0;
	////////////////////////////////////////////////////////////
	// Interrupt and oscillator mode inputs come from other domains
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			intrSync1_r <= 1'b0;
			intrSync2_r <= 1'b0;
			oscSync1_r <= 3'h0;
			oscSync2_r <= 3'h0;
		end else begin
			intrSync1_r <= intrEvent;
			intrSync2_r <= intrSync1_r;
			oscSync1_r <= oscModeSel;
			oscSync2_r <= oscSync1_r;
		end
	end
	////////////////////////////////////////////////////////////
	always @* begin
		ctrl_nxt = ctrl_r;
		if (regWrStb && regAddr == `CDC_ADDR_CTRL)
			ctrl_nxt = regWrData & `CDC_WMASK;
		// Hardware recovery wins over a simultaneous software write
		if (intrSync2_r && ctrl_r[`CDC_BIT_ROI]) begin
			ctrl_nxt[`CDC_BIT_RATIO_APPLY_ENABLE] = 1'b0;
		end
	end
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `CDC_RESET_VAL;
			regRdData_r <= 16'h0000;
			ctrlOut_r <= `CDC_RESET_VAL;
			pllRun_r <= 1'b0;
			rcClkEn_r <= 1'b0;
			sysClkEn_r <= 1'b0;
			periphClkEn_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			ctrlOut_r <= ctrl_r;
			pllRun_r <= ctrl_r[`CDC_BIT_USB_PLL_ALWAYS_ON] || oscSync2_r == `CDC_PLL_MODE_A ||
				oscSync2_r == `CDC_PLL_MODE_B;
			rcClkEn_r <= rcTick;
			sysClkEn_r <= sysTick;
			periphClkEn_r <= periphTick;
			if (regRdStb) begin
				case (regAddr)
				`CDC_ADDR_CTRL: regRdData_r <= ctrl_r;
				`CDC_ADDR_STAT: regRdData_r <= {12'h000, pllRun_r, periphClkEn_r, sysClkEn_r, rcClkEn_r};
				default: regRdData_r <= 16'h0000;
				endcase
			end else begin
				regRdData_r <= 16'h0000;
			end
		end
	end
	////////////////////////////////////////////////////////////
	// One divider per clock enable, each switching only at its boundary
	pow2_clock_gate #(.CNT_W(CNT_W)) uRcDiv (
		.sys_clk(sys_clk),
		.rst(rst),
		.shiftSel(rcShift),
		.tickOut_r(rcTick)
	);
	pow2_clock_gate #(.CNT_W(CNT_W)) uSysDiv (
		.sys_clk(sys_clk),
		.rst(rst),
		.shiftSel(cpShift),
		.tickOut_r(sysTick)
	);
	pow2_clock_gate #(.CNT_W(CNT_W)) uDozeDiv (
		.sys_clk(sys_clk),
		.rst(rst),
		.shiftSel(dozeShift),
		.tickOut_r(periphTick)
	);
endmodule

// ---- verification/cdc_checker_properties.sv ----
// Checker of the clock divider block ports
`timescale 1ns/1ns
module cdc_checker (
	input wire sys_clk,
	input wire rst,
	input wire regWrStb,
	input wire intrEvent,
	input wire [2:0] oscModeSel,
	input wire rcClkEn_r,
	input wire sysClkEn_r,
	input wire periphClkEn_r,
	input wire pllRun_r,
	input wire [15:0] ctrlOut_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_rst_val: assert property ($past(rst) |-> ctrlOut_r == 16'h3100) else $error("bad reset");
	a_pll_on: assert property (ctrlOut_r[5] [*3] |-> pllRun_r) else $error("pll off");
	a_pll_off: assert property ((!ctrlOut_r[5] && oscModeSel != 3'h3 && oscModeSel != 3'h1) [*5] |-> !pllRun_r)
		else $error("pll on");
	a_rc_gap: assert property ((ctrlOut_r[10:8] == 3'h1) [*3] ##0 rcClkEn_r |=> !rcClkEn_r) else $error("rc");
	a_sys_gap: assert property ((ctrlOut_r[7:6] == 2'h1) [*3] ##0 sysClkEn_r |=> !sysClkEn_r) else $error("sys");
	a_doze_gap: assert property ((ctrlOut_r[14:11] == 4'h3) [*3] ##0 periphClkEn_r |=> !periphClkEn_r)
		else $error("doze");
	a_roi_clear: assert property ($rose(intrEvent) && ctrlOut_r[15] |-> ##[3:5] !ctrlOut_r[11]) else $error("roi");
	a_roi_keep: assert property ($fell(ctrlOut_r[11]) |-> $past(ctrlOut_r[15]) || $past(regWrStb, 2))
		else $error("doze lost");
	cover property ($rose(intrEvent) && ctrlOut_r[15]);
	cover property (pllRun_r && !ctrlOut_r[5]);
	cover property ((ctrlOut_r[14:11] == 4'h3) [*3] ##0 periphClkEn_r);
endmodule
bind clock_divider_doze_control cdc_checker cdc_checker_i (.sys_clk(sys_clk), .rst(rst), .regWrStb(regWrStb),
	.intrEvent(intrEvent), .oscModeSel(oscModeSel), .rcClkEn_r(rcClkEn_r), .sysClkEn_r(sysClkEn_r),
	.periphClkEn_r(periphClkEn_r), .pllRun_r(pllRun_r), .ctrlOut_r(ctrlOut_r));

// ---- verification/tb.sv ----
// Self-checking bench of the clock divider block
`timescale 1ns/1ns
module tb;
	reg sys_clk = 0, rst = 1, regWrStb = 0, regRdStb = 0, intrEvent = 0;
	reg [3:0] regAddr = 4'h0;
	reg [15:0] regWrData = 16'h0000;
	reg [2:0] oscModeSel = 3'h0;
	wire [15:0] regRdData_r, ctrlOut_r;
	wire rcClkEn_r, sysClkEn_r, periphClkEn_r, pllRun_r;
	int n_mismatch = 0, cmp_count = 0, cyc = 0, p, r, s;
	clock_divider_doze_control clock_divider_doze_control_i (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_r(regRdData_r),
		.intrEvent(intrEvent), .oscModeSel(oscModeSel), .rcClkEn_r(rcClkEn_r), .sysClkEn_r(sysClkEn_r),
		.periphClkEn_r(periphClkEn_r), .pllRun_r(pllRun_r), .ctrlOut_r(ctrlOut_r));
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report;
		end
	end
	task final_report;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] g, e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= w;
		regRdStb <= !w;
		@(posedge sys_clk);
		regWrStb <= 0;
		regRdStb <= 0;
		@(negedge sys_clk);
		if (!w) chk(regRdData_r, d);
	endtask
	task cnt;
		repeat (300) @(posedge sys_clk);
		p = 0;
		r = 0;
		s = 0;
		repeat (512) begin
			@(negedge sys_clk);
			p += periphClkEn_r;
			r += rcClkEn_r;
			s += sysClkEn_r;
		end
	endtask
	task intr(input logic [15:0] c, e);
		bus(1, 4'h0, c);
		@(posedge sys_clk);
		intrEvent <= 1;
		@(posedge sys_clk);
		intrEvent <= 0;
		repeat (5) @(posedge sys_clk);
		bus(0, 4'h0, e);
	endtask
	task t_divide;
		for (int i = 0; i < 8; i++) begin
			bus(1, 4'h0, {1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 6'h00});
			cnt;
			chk(p, 512 >> i);
			chk(r, 512 >> (i == 7 ? 8 : i));
			chk(s, 512 >> i[1:0]);
		end
		bus(1, 4'h0, 16'h7000);
		cnt;
		chk(p, 512);
		$display("divide done");
	endtask
	task t_roi;
		intr(16'hB900, 16'hB100);
		@(negedge sys_clk);
		chk(ctrlOut_r, 16'hB100);
		cnt;
		chk(p, 512);
		intr(16'h3900, 16'h3900);
		$display("recover done");
	endtask
	task t_pll;
		for (int m = 0; m < 8; m++) begin
			oscModeSel <= m[2:0];
			repeat (6) @(posedge sys_clk);
			@(negedge sys_clk);
			chk(pllRun_r, m == 3 || m == 1);
		end
		bus(1, 4'h0, 16'h313F);
		bus(0, 4'h0, 16'h3120);
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(pllRun_r, 1);
		bus(1, 4'h0, 16'h3020);
		repeat (300) @(posedge sys_clk);
		bus(0, 4'h1, 16'h000F);
		$display("pll done");
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 0;
		bus(0, 4'h0, 16'h3100);
		bus(0, 4'h9, 16'h0000);
		t_divide;
		t_roi;
		t_pll;
		final_report;
	end
endmodule
